// File: verilog/ebgc_pkg.sv
// package: constants and types for the external bus grant controller
package ebgc_pkg;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 24;
  localparam int WAIT_W = 3;
  localparam int ZONES = 5;
  localparam logic [2:0] PWAIT_RST = 3'h7;
  localparam logic [2:0] DWAIT_RST = 3'h7;

  typedef enum logic {EBGC_SP_PROG, EBGC_SP_DATA} ebgc_space_e;

  // one external access request to the sequencer
  typedef struct packed {
    logic valid;
    logic boot;
    logic write;
    ebgc_space_e space;
    logic [2:0] zone;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic paired;
  } ebgc_acc_s;

  // memory pin bundle: value and enable
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic addr_oe;
    logic [DATA_W-1:0] data;
    logic data_oe;
    logic prog_sel_n;
    logic data_sel_n;
    logic boot_sel_n;
    logic rd_n;
    logic wr_n;
    logic ctl_oe;
  } ebgc_pins_s;
endpackage : ebgc_pkg

// File: verilog/ebgc_ctrl.sv
// external memory port sequencer with bus request and grant arbitration
`timescale 1ns/1ps
`default_nettype none

// How it works
// - peripherals are plain data-memory reads and writes, timed by their zone wait states.
// - with run-while-granted on, the core runs on and stalls only for an external access.
// - with run-while-granted off, the core is halted before the grant is issued.
// - on a recognized request the address, data, strobes and selects are floated.
// - the grant goes low only after the pins are floated; the clock output keeps running.
// - a paired program/data access is split, the second done after the request goes away.
// - a grant never changes core state; the stalled access resumes exactly where it stopped.
// - on release the grant rises first and the pins are driven again only afterwards.
// - under reset requests are granted as usual and serial and flag pins float.
// - during boot a request is honoured only once the current byte with its waits ends.
// - internal accesses keep selects and strobes high and buses floating.
// - in reset buses float and controls are high; boot drives boot select and read.
// - the core is stalled for wait states and for contention on the one memory port.
// - each data zone has a 3-bit wait count adding cycles to the strobe.
// - address first, then select, then strobe; the strobe ends before the select.
module ebgc_ctrl #(
  parameter int ZONES = ebgc_pkg::ZONES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ext_bus_req_n,
  input wire logic run_while_granted,
  input wire logic [ebgc_pkg::WAIT_W-1:0] prog_wait,
  input wire logic [ZONES*ebgc_pkg::WAIT_W-1:0] zone_wait,
  input wire ebgc_pkg::ebgc_acc_s acc_req,
  input wire logic core_halt_ok,
  output logic acc_ready,
  output logic [ebgc_pkg::DATA_W-1:0] acc_rdata,
  output logic core_stall,
  output logic ext_bus_gnt_n,
  output ebgc_pkg::ebgc_pins_s pins,
  input wire logic [ebgc_pkg::DATA_W-1:0] mem_data_in,
  output logic clock_output,
  output logic periph_pins_oe
);
  typedef enum {
    ST_IDLE, ST_ADDR, ST_SEL, ST_STRB, ST_END, ST_FLOAT, ST_GRANT, ST_UNGRANT
  } ebgc_state_e;

  ebgc_state_e state_q;
  logic req_q;
  logic [2:0] wait_q;
  logic resume_pair_q;
  ebgc_pkg::ebgc_acc_s cur_q;
  logic [2:0] acc_wait;
  logic can_grant;

  // registered request, active high internally; sampled in reset too
  always_ff @(posedge sys_clk) begin
    req_q <= ~ext_bus_req_n;
  end

  // zone wait select
  always_comb begin
    acc_wait = prog_wait;
    for (int z = 0; z < ZONES; z++) begin
      if (acc_req.space == ebgc_pkg::EBGC_SP_DATA && acc_req.zone == 3'(z)) begin
        acc_wait = zone_wait[z*ebgc_pkg::WAIT_W +: ebgc_pkg::WAIT_W];
      end
    end
  end

  // grant allowed when idle; halt first unless run-while-granted
  assign can_grant = req_q && (run_while_granted || core_halt_ok || rst);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cur_q <= '0;
      wait_q <= 3'h0;
      resume_pair_q <= 1'b0;
      acc_rdata <= '0;
      // grant path stays live under reset
      case (state_q)
        ST_FLOAT: state_q <= ST_GRANT;
        ST_GRANT: begin
          if (!req_q) begin
            state_q <= ST_UNGRANT;
          end
        end
        ST_UNGRANT: state_q <= ST_IDLE;
        default: begin
          if (req_q) begin
            state_q <= ST_FLOAT;
          end else begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end else begin
      case (state_q)
        ST_IDLE: begin
          // second half of a split pair goes before a new grant
          if (can_grant && !(resume_pair_q && acc_req.valid)) begin
            state_q <= ST_FLOAT;
          end else if (acc_req.valid) begin
            cur_q <= acc_req;
            wait_q <= acc_wait;
            resume_pair_q <= 1'b0;
            state_q <= ST_ADDR;
          end
        end
        ST_ADDR: state_q <= ST_SEL;
        ST_SEL: state_q <= ST_STRB;
        ST_STRB: begin
          if (wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
          end else begin
            if (!cur_q.write) begin
              acc_rdata <= mem_data_in;
            end
            state_q <= ST_END;
          end
        end
        ST_END: begin
          // boot byte or first of a pair done: request honoured here
          resume_pair_q <= cur_q.paired;
          state_q <= req_q ? ST_FLOAT : ST_IDLE;
        end
        ST_FLOAT: state_q <= ST_GRANT;
        ST_GRANT: begin
          if (!req_q) begin
            state_q <= ST_UNGRANT;
          end
        end
        ST_UNGRANT: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // handshake to the core; stalled accesses are held by the core untouched
  always_comb begin
    acc_ready = (state_q == ST_END);
    core_stall = acc_req.valid && !acc_ready;
    if (!run_while_granted && ((state_q == ST_IDLE && req_q) || state_q == ST_FLOAT ||
        state_q == ST_GRANT)) begin
      core_stall = 1'b1;
    end
  end

  // pin drive from state
  always_comb begin
    pins = '0;
    pins.prog_sel_n = 1'b1;
    pins.data_sel_n = 1'b1;
    pins.boot_sel_n = 1'b1;
    pins.rd_n = 1'b1;
    pins.wr_n = 1'b1;
    pins.ctl_oe = !(state_q == ST_FLOAT || state_q == ST_GRANT ||
      state_q == ST_UNGRANT);
    if (state_q == ST_ADDR || state_q == ST_SEL || state_q == ST_STRB || state_q == ST_END) begin
      pins.addr = cur_q.addr;
      pins.addr_oe = 1'b1;
      pins.data = cur_q.wdata;
      pins.data_oe = cur_q.write;
      if (state_q != ST_ADDR) begin
        pins.boot_sel_n = !cur_q.boot;
        pins.prog_sel_n = cur_q.boot || cur_q.space != ebgc_pkg::EBGC_SP_PROG;
        pins.data_sel_n = cur_q.boot || cur_q.space != ebgc_pkg::EBGC_SP_DATA;
      end
      if (state_q == ST_STRB) begin
        pins.rd_n = cur_q.write;
        pins.wr_n = !cur_q.write || cur_q.boot;
      end
    end
  end

  // grant output registered: low one clock after float, live in reset too
  always_ff @(posedge sys_clk) begin
    ext_bus_gnt_n <= !(state_q == ST_FLOAT || (state_q == ST_GRANT && req_q));
  end

  assign clock_output = sys_clk;
  assign periph_pins_oe = !rst;

  property p_grant_after_float;
    @(posedge sys_clk) disable iff (rst)
      $fell(ext_bus_gnt_n) |-> !$past(pins.ctl_oe) && !pins.ctl_oe;
  endproperty
  a_grant_after_float: assert property (p_grant_after_float) else $error("grant before float");

  property p_float_in_grant;
    @(posedge sys_clk) disable iff (rst)
      !ext_bus_gnt_n |-> !pins.ctl_oe && !pins.addr_oe && !pins.data_oe;
  endproperty
  a_float_in_grant: assert property (p_float_in_grant) else $error("pins driven in grant");

  property p_release_order;
    @(posedge sys_clk) disable iff (rst)
      $rose(ext_bus_gnt_n) |-> !pins.ctl_oe ##1 pins.ctl_oe;
  endproperty
  a_release_order: assert property (p_release_order) else $error("pins before grant release");

  property p_grant_latency;
    @(posedge sys_clk) disable iff (rst)
      (state_q == ST_IDLE && can_grant) |-> ##2 !ext_bus_gnt_n;
  endproperty
  a_grant_latency: assert property (p_grant_latency) else $error("grant late");

  property p_halt_first;
    @(posedge sys_clk) disable iff (rst)
      (!ext_bus_gnt_n && !run_while_granted) |-> core_stall;
  endproperty
  a_halt_first: assert property (p_halt_first) else $error("core ran while granted");

  property p_strobe_order;
    @(posedge sys_clk) disable iff (rst)
      $fell(pins.rd_n) |-> $past(!pins.prog_sel_n || !pins.data_sel_n || !pins.boot_sel_n);
  endproperty
  a_strobe_order: assert property (p_strobe_order) else $error("strobe before select");

  property p_idle_quiet;
    @(posedge sys_clk) disable iff (rst)
      state_q == ST_IDLE |-> pins.rd_n && pins.wr_n && pins.prog_sel_n && !pins.addr_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("pins active when internal");

  property p_boot_no_write;
    @(posedge sys_clk) disable iff (rst)
      !pins.boot_sel_n |-> pins.wr_n && pins.prog_sel_n && pins.data_sel_n;
  endproperty
  a_boot_no_write: assert property (p_boot_no_write) else $error("boot drove write");

  property p_wait_len;
    @(posedge sys_clk) disable iff (rst)
      (state_q == ST_STRB && wait_q != 3'h0) |=>
        state_q == ST_STRB && !(pins.rd_n && pins.wr_n);
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("strobe cut short");

  property p_strobe_end;
    @(posedge sys_clk) disable iff (rst)
      (state_q == ST_STRB && wait_q == 3'h0) |=>
        pins.rd_n && pins.wr_n && !(pins.prog_sel_n && pins.data_sel_n && pins.boot_sel_n);
  endproperty
  a_strobe_end: assert property (p_strobe_end) else $error("select ended with strobe");
endmodule : ebgc_ctrl

`default_nettype wire

// File: test/ebgc_master.sv
// external bus master model for the grant controller
`timescale 1ns/1ps
`default_nettype none
module ebgc_master (
  input wire logic sys_clk,
  input wire logic ext_bus_gnt_n,
  output logic ext_bus_req_n
);
  initial ext_bus_req_n = 1'b1;
  // drive the request, only just after a falling edge
  task automatic req(input logic v);
    @(negedge sys_clk);
    ext_bus_req_n = v;
  endtask : req
  // wait, bounded, for the grant to reach level v
  task automatic wait_gnt(input logic v, output logic got);
    int i;
    got = 1'b0;
    for (i = 0; i < 200 && !got; i++) begin
      @(negedge sys_clk);
      got = (ext_bus_gnt_n === v);
    end
  endtask : wait_gnt
endmodule : ebgc_master
`default_nettype wire

// File: test/tb_external_bus_grant_ctrl.sv
// self-checking bench for the external bus grant controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb_external_bus_grant_ctrl;
  logic sys_clk = 0, rst = 1, rwg = 0, hok = 1, got;
  logic [2:0] pw = 0;
  logic [14:0] zw = 0;
  ebgc_pkg::ebgc_acc_s acc = '0;
  logic [23:0] din = '0, rdata;
  logic rdy, stall, gnt_n, req_n, cko, poe;
  ebgc_pkg::ebgc_pins_s pins;
  int num_errors = 0, compares = 0, i;
  logic [24:0] expq[$];
  always #2 sys_clk = ~sys_clk;
  ebgc_ctrl DUT (.sys_clk(sys_clk), .rst(rst), .ext_bus_req_n(req_n), .run_while_granted(rwg),
    .prog_wait(pw), .zone_wait(zw), .acc_req(acc), .core_halt_ok(hok), .acc_ready(rdy),
    .acc_rdata(rdata), .core_stall(stall), .ext_bus_gnt_n(gnt_n), .pins(pins),
    .mem_data_in(din), .clock_output(cko), .periph_pins_oe(poe));
  ebgc_master m (.sys_clk(sys_clk), .ext_bus_gnt_n(gnt_n), .ext_bus_req_n(req_n));
  always @(negedge sys_clk) if (rdy === 1'b1 && expq.size() > 0) begin
    automatic logic [24:0] e = expq.pop_front();
    if (!e[24]) `CHK(rdata, e[23:0])
  end
  task automatic access(input logic wr, input ebgc_pkg::ebgc_space_e sp, input logic [2:0] z);
    int n, lo;
    logic [2:0] w, sel;
    @(negedge sys_clk);
    w = (sp == ebgc_pkg::EBGC_SP_PROG) ? pw : zw[z*3 +: 3];
    sel = acc.boot ? 3'b110 : (sp ? 3'b101 : 3'b011);
    acc.valid = 1;
    acc.write = wr;
    acc.space = sp;
    acc.zone = z;
    acc.addr = 14'($urandom);
    acc.wdata = 24'($urandom);
    din = 24'($urandom);
    expq.push_back({wr, din});
    lo = 0;
    for (n = 0; n < 100 && rdy !== 1'b1; n++) begin
      @(negedge sys_clk);
      if (pins.rd_n === 1'b0 || pins.wr_n === 1'b0) begin
        lo++;
        `CHK({pins.prog_sel_n, pins.data_sel_n, pins.boot_sel_n}, sel)
        `CHK({pins.rd_n, pins.wr_n, pins.addr}, {wr, !wr, acc.addr})
        if (wr) `CHK({pins.data_oe, pins.data}, {1'b1, acc.wdata})
      end
    end
    `CHK(rdy, 1'b1)
    @(negedge sys_clk) acc.valid = 0;
    `CHK(lo, w + 1)
  endtask : access
  task automatic grant_check(input logic run);
    rwg = run;
    hok = run;
    m.req(1'b0);
    repeat (10) @(negedge sys_clk);
    `CHK(gnt_n, run ? 1'b0 : 1'b1)
    `CHK(stall, !run)
    hok = 1;
    m.wait_gnt(1'b0, got);
    `CHK(got, 1'b1)
    `CHK({pins.addr_oe, pins.data_oe, pins.ctl_oe}, 3'h0)
    `CHK(stall, !run)
    `CHK({poe, cko}, {1'b1, sys_clk})
    acc.valid = 1'b1;
    @(negedge sys_clk);
    `CHK({stall, gnt_n}, 2'b10)
    acc.valid = 1'b0;
    m.req(1'b1);
    m.wait_gnt(1'b1, got);
    `CHK(got, 1'b1)
  endtask : grant_check
  task automatic report_and_stop;
    if (num_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h51f4));
    pw = 3'($urandom);
    zw = 15'($urandom);
    repeat (12) @(negedge sys_clk);
    `CHK({pins.prog_sel_n, pins.data_sel_n, pins.boot_sel_n, pins.rd_n, pins.wr_n}, 5'h1F)
    `CHK({pins.addr_oe, pins.data_oe, gnt_n, poe}, 4'h2)
    rst = 0;
    for (i = 0; i < 10; i++) access(1'($urandom), ebgc_pkg::ebgc_space_e'($urandom), 3'(i % 5));
    grant_check(1'b1);
    grant_check(1'b0);
    acc.boot = 1'b1;
    acc.paired = 1'b1;
    fork
      access(1'b0, ebgc_pkg::EBGC_SP_PROG, 3'h0);
      m.req(1'b0);
    join
    m.wait_gnt(1'b0, got);
    `CHK(got, 1'b1)
    acc.boot = 1'b0;
    acc.paired = 1'b0;
    m.req(1'b1);
    m.wait_gnt(1'b1, got);
    access(1'b0, ebgc_pkg::EBGC_SP_DATA, 3'h4);
    rst = 1;
    m.req(1'b0);
    m.wait_gnt(1'b0, got);
    `CHK({got, poe, pins.ctl_oe}, 3'h4)
    `CHK({gnt_n, cko}, {1'b0, sys_clk})
    m.req(1'b1);
    m.wait_gnt(1'b1, got);
    @(negedge sys_clk) rst = 0;
    `CHK(expq.size(), 0)
    report_and_stop();
  end
endmodule : tb_external_bus_grant_ctrl
`default_nettype wire
